//--- logic/asp_top.sv
// Purpose: Serial audio port with registers, link and compander.
// Assumes: Pins are asynchronous; triggers come from this clock domain.
// Notes:   Registers are eight bits wide on a plain strobe port.
//
// Contract
// - Read low first; high read ends sample.
// - Stereo receive shows channel of held sample.
// - Master mode drives SCK and WS.
// - SCK equals clock over twice ratio.
// - Numerator and denominator split over three registers.
// - Short words padded with low zeros.
// - Received words keep sixteen top bits.
// - Slave mode takes SCK and WS in.
// - Slave sends zeros after buffer exhausted; this port resends the last held word.
// - Mono receive drops right channel words.
// - Mono transmit repeats word on both.
// - Word counter snapshots and clears on trigger.
// - Trigger select chooses snapshot source.
// - Word counter saturates at maximum.
// - Enabled port expands and compresses samples.
// - Stand-alone expansion result one cycle later.
// - Stand-alone compression result one cycle later.
// - MSB first, WS low left.
// - Receive flag sets, high read clears.
// - Port enable runs link; compander standalone.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
module asp_top (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       ce_i,
  // Register port
  input  wire logic [asp_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [asp_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output      logic [asp_pkg::DATA_W-1:0] reg_rdata_o,
  // Link pins
  input  wire logic                       sck_i,
  output      logic                       sck_o,
  output      logic                       sck_oe_n_o,
  input  wire logic                       ws_i,
  output      logic                       ws_o,
  output      logic                       ws_oe_n_o,
  input  wire logic                       sd_rx_i,
  output      logic                       sd_tx_o,
  // Snapshot triggers
  input  wire logic                       usb_sof_i,
  input  wire logic                       timer_one_cmp_zero_i,
  input  wire logic                       pin_change_trigger_i,
  // Transfer events
  output      logic                       rx_dma_trigger_o,
  output      logic                       tx_dma_trigger_o
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0] audio_config_a;
  logic [7:0] audio_config_b;
  logic [7:0] clk_frac_reg0;
  logic [7:0] clk_frac_reg1;
  logic [7:0] clk_frac_reg2;
  logic       wr_hit_data_h;
  logic       wr_hit_wcnt;
  logic       rd_hit_data_h;

  assign wr_hit_data_h = reg_wr_i && reg_addr_i == asp_pkg::OFF_DATA_H;
  assign wr_hit_wcnt   = reg_wr_i && reg_addr_i == asp_pkg::OFF_WCNT;
  assign rd_hit_data_h = reg_rd_i && reg_addr_i == asp_pkg::OFF_DATA_H;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      audio_config_a <= asp_pkg::RST_CFG_A;
      audio_config_b <= asp_pkg::RST_CFG_B;
      clk_frac_reg0  <= asp_pkg::RST_FRAC0;
      clk_frac_reg1  <= asp_pkg::RST_FRAC1;
      clk_frac_reg2  <= asp_pkg::RST_FRAC2;
    end else if (ce_i && reg_wr_i) begin
      unique case (reg_addr_i)
        asp_pkg::OFF_CFG_A: audio_config_a <= reg_wdata_i;
        asp_pkg::OFF_CFG_B: audio_config_b <= reg_wdata_i;
        asp_pkg::OFF_FRAC0: clk_frac_reg0  <= reg_wdata_i;
        asp_pkg::OFF_FRAC1: clk_frac_reg1  <= reg_wdata_i;
        asp_pkg::OFF_FRAC2: clk_frac_reg2  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  logic                             port_enable;
  logic                             master_select;
  logic                             rx_mono_enable;
  logic                             tx_mono_enable;
  logic                             compress_enable;
  logic                             expand_enable;
  logic [asp_pkg::WSIZE_W-1:0]      word_size_field;
  logic [asp_pkg::TRIG_W-1:0]       trigger_select;
  logic [asp_pkg::NUM_W-1:0]        div_num;
  logic [asp_pkg::DEN_W-1:0]        clk_ratio_a;
  logic                             run;
  logic                             mst_run;

  assign port_enable     = audio_config_a[asp_pkg::CFGA_PORT_EN];
  assign master_select   = audio_config_a[asp_pkg::CFGA_MASTER];
  assign rx_mono_enable  = audio_config_a[asp_pkg::CFGA_RX_MONO];
  assign tx_mono_enable  = audio_config_a[asp_pkg::CFGA_TX_MONO];
  assign compress_enable = audio_config_a[asp_pkg::CFGA_COMPR];
  assign expand_enable   = audio_config_a[asp_pkg::CFGA_EXPAND];
  assign word_size_field =
    audio_config_b[asp_pkg::CFGB_WSIZE +: asp_pkg::WSIZE_W];
  assign trigger_select  =
    audio_config_b[asp_pkg::CFGB_TRIG +: asp_pkg::TRIG_W];
  assign div_num     = {clk_frac_reg2[6:0], clk_frac_reg1};
  assign clk_ratio_a = {clk_frac_reg2[asp_pkg::FRAC2_DEN8], clk_frac_reg0};
  assign run     = port_enable;
  assign mst_run = port_enable && master_select;

  // ****************************************************************
  // Pin synchronisers and link clock
  // ****************************************************************
  logic sck_s1, sck_s2, ws_s1, ws_s2, sd_s1, sd_s2;
  logic pin_s1, pin_s2, pin_s3;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {sck_s1, sck_s2, ws_s1, ws_s2} <= 4'h0;
      {sd_s1, sd_s2, pin_s1, pin_s2, pin_s3} <= 5'h00;
    end else if (ce_i) begin
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      ws_s1  <= ws_i;
      ws_s2  <= ws_s1;
      sd_s1  <= sd_rx_i;
      sd_s2  <= sd_s1;
      pin_s1 <= pin_change_trigger_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic div_sck;
  logic link_sck;
  logic link_sck_d;
  logic link_ws;
  logic ws_drv;
  logic sck_rise;
  logic sck_fall;

  asp_sck_div u_div (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .run_i      (mst_run),
    .num_i      (div_num),
    .den_i      (clk_ratio_a),
    .sck_o      (div_sck)
  );

  assign link_sck = master_select ? div_sck : sck_s2;
  assign link_ws  = master_select ? ws_drv : ws_s2;
  assign sck_rise = run && link_sck && !link_sck_d;
  assign sck_fall = run && !link_sck && link_sck_d;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_sck_d <= 1'b0;
    end else if (ce_i) begin
      link_sck_d <= link_sck;
    end
  end

  assign sck_o      = div_sck;
  assign ws_o       = ws_drv;
  assign sck_oe_n_o = !mst_run;
  assign ws_oe_n_o  = !mst_run;

  // ****************************************************************
  // Master word select
  // ****************************************************************
  logic [asp_pkg::WSIZE_W-1:0] bit_cnt;
  logic [asp_pkg::WSIZE_W-1:0] next_bit_cnt;

  assign next_bit_cnt = (bit_cnt == word_size_field) ? '0 : bit_cnt + 1'b1;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt <= '0;
      ws_drv  <= 1'b0;
    end else if (ce_i) begin
      if (!mst_run) begin
        bit_cnt <= '0;
        ws_drv  <= 1'b0;
      end else if (sck_fall) begin
        bit_cnt <= next_bit_cnt;
        if (next_bit_cnt == word_size_field) begin
          ws_drv <= ~ws_drv;
        end
      end
    end
  end

  // ****************************************************************
  // Word boundaries seen at rising edges
  // ****************************************************************
  logic ws_smp;
  logic ws_chg;
  logic new_word;

  assign ws_chg = sck_rise && (link_ws != ws_smp);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ws_smp   <= 1'b0;
      new_word <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        ws_smp   <= 1'b0;
        new_word <= 1'b0;
      end else if (sck_rise) begin
        ws_smp   <= link_ws;
        new_word <= ws_chg;
      end else if (sck_fall) begin
        new_word <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  logic [15:0]                 rx_sr;
  logic [asp_pkg::RXCNT_W-1:0] rx_cnt;
  logic [15:0]                 next_rx_sr;
  logic [asp_pkg::RXCNT_W-1:0] next_rx_cnt;
  logic [15:0]                 rx_word;
  logic                        rx_deliver;

  always_comb begin
    next_rx_sr  = rx_sr;
    next_rx_cnt = rx_cnt;
    if (rx_cnt < asp_pkg::RX_FULL) begin
      next_rx_sr  = {rx_sr[14:0], sd_s2};
      next_rx_cnt = rx_cnt + 1'b1;
    end
  end

  assign rx_word = next_rx_sr << (asp_pkg::RX_FULL - next_rx_cnt);
  assign rx_deliver = ws_chg && (!rx_mono_enable || !ws_smp);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sr  <= '0;
      rx_cnt <= '0;
    end else if (ce_i) begin
      if (!run || ws_chg) begin
        rx_sr  <= '0;
        rx_cnt <= '0;
      end else if (sck_rise) begin
        rx_sr  <= next_rx_sr;
        rx_cnt <= next_rx_cnt;
      end
    end
  end

  // ****************************************************************
  // Compander
  // ****************************************************************
  logic [7:0]  tx_low_stage;
  logic [15:0] cmp_in;
  logic [7:0]  cmp_out;
  logic [15:0] exp_out;

  assign cmp_in = run ? rx_word : {reg_wdata_i, tx_low_stage};

  asp_ulaw u_ulaw (
    .pcm_i  (cmp_in),
    .code_o (cmp_out),
    .code_i (reg_wdata_i),
    .pcm_o  (exp_out)
  );

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic [15:0] tx_hold;
  logic [15:0] tx_cur;
  logic [15:0] tx_sr;
  logic        tx_fetch;
  logic [15:0] tx_load;
  logic        tx_left_right;

  assign tx_fetch = sck_fall && new_word && (!tx_mono_enable || !ws_smp);
  assign tx_load  = tx_fetch ? tx_hold : tx_cur;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_low_stage <= 8'h00;
      tx_hold      <= '0;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == asp_pkg::OFF_DATA_L) begin
        tx_low_stage <= reg_wdata_i;
      end else if (wr_hit_data_h && run) begin
        tx_hold <= expand_enable ? exp_out : {reg_wdata_i, tx_low_stage};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_cur        <= '0;
      tx_sr         <= '0;
      sd_tx_o       <= 1'b0;
      tx_left_right <= 1'b0;
    end else if (ce_i) begin
      if (!run) begin
        tx_sr   <= '0;
        sd_tx_o <= 1'b0;
      end else if (sck_fall && new_word) begin
        if (tx_fetch) begin
          tx_cur        <= tx_hold;
          tx_left_right <= ~ws_smp;
        end
        sd_tx_o <= tx_load[15];
        tx_sr   <= {tx_load[14:0], 1'b0};
      end else if (sck_fall) begin
        sd_tx_o <= tx_sr[15];
        tx_sr   <= {tx_sr[14:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Readable data registers and flags
  // ****************************************************************
  logic [7:0] audio_data_high;
  logic [7:0] audio_data_low;
  logic       rx_left_right;
  logic       rx_complete_flag;
  logic       tx_complete_flag;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      audio_data_high <= 8'h00;
      audio_data_low  <= 8'h00;
      rx_left_right   <= 1'b0;
    end else if (ce_i) begin
      if (rx_deliver) begin
        rx_left_right <= ws_smp;
        if (compress_enable) begin
          audio_data_high <= cmp_out;
          audio_data_low  <= 8'h00;
        end else begin
          audio_data_high <= rx_word[15:8];
          audio_data_low  <= rx_word[7:0];
        end
      end else if (wr_hit_data_h && !run) begin
        if (expand_enable && !compress_enable) begin
          audio_data_high <= exp_out[15:8];
          audio_data_low  <= exp_out[7:0];
        end else if (compress_enable && !expand_enable) begin
          audio_data_high <= cmp_out;
        end
      end
    end
  end

  // A sample landing in the same cycle as the clearing read wins.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_complete_flag <= 1'b0;
      tx_complete_flag <= 1'b0;
    end else if (ce_i) begin
      if (rx_deliver) begin
        rx_complete_flag <= 1'b1;
      end else if (rd_hit_data_h) begin
        rx_complete_flag <= 1'b0;
      end
      if (tx_fetch) begin
        tx_complete_flag <= 1'b1;
      end else if (wr_hit_data_h) begin
        tx_complete_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_dma_trigger_o <= 1'b0;
      tx_dma_trigger_o <= 1'b0;
    end else if (ce_i) begin
      rx_dma_trigger_o <= rx_deliver;
      tx_dma_trigger_o <= tx_fetch;
    end
  end

  // ****************************************************************
  // Word counter
  // ****************************************************************
  logic [asp_pkg::WCNT_W-1:0] wcnt;
  logic [asp_pkg::WCNT_W-1:0] wcnt_snap;
  logic                       trig_hit;
  logic                       snap_now;

  always_comb begin
    unique case (trigger_select)
      asp_pkg::TRIG_NONE:  trig_hit = 1'b0;
      asp_pkg::TRIG_SOF:   trig_hit = usb_sof_i;
      asp_pkg::TRIG_TIMER: trig_hit = timer_one_cmp_zero_i;
      asp_pkg::TRIG_PIN:   trig_hit = pin_s2 ^ pin_s3;
    endcase
  end

  assign snap_now = trig_hit || wr_hit_wcnt;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wcnt      <= '0;
      wcnt_snap <= '0;
    end else if (ce_i) begin
      if (snap_now) begin
        wcnt_snap <= wcnt;
        wcnt      <= ws_chg ? asp_pkg::WCNT_W'(1) : '0;
      end else if (ws_chg && wcnt != '1) begin
        wcnt <= wcnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // high read closes sample.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          asp_pkg::OFF_CFG_A:  reg_rdata_o <= audio_config_a;
          asp_pkg::OFF_CFG_B:  reg_rdata_o <= audio_config_b;
          asp_pkg::OFF_STATUS: reg_rdata_o <= {wcnt_snap[9:8],
            rx_left_right, tx_left_right, 2'b00, tx_complete_flag,
            rx_complete_flag};
          asp_pkg::OFF_FRAC0:  reg_rdata_o <= clk_frac_reg0;
          asp_pkg::OFF_FRAC1:  reg_rdata_o <= clk_frac_reg1;
          asp_pkg::OFF_FRAC2:  reg_rdata_o <= clk_frac_reg2;
          asp_pkg::OFF_WCNT:   reg_rdata_o <= wcnt_snap[7:0];
          asp_pkg::OFF_DATA_L: reg_rdata_o <= audio_data_low;
          asp_pkg::OFF_DATA_H: reg_rdata_o <= audio_data_high;
          default:             reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

//--- inc/asp_pkg.sv
// Purpose: Shared constants of the serial audio port.
// Assumes: Byte-wide register port, 16-bit sample path.
// Notes:   Offsets are word indices on the plain register port.
package asp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 8;
  localparam int SAMPLE_W  = 16;
  localparam int WCNT_W    = 10;
  localparam int NUM_W     = 15;
  localparam int DEN_W     = 9;
  localparam int DIV_ACC_W = 16;
  localparam int WSIZE_W   = 5;
  localparam int TRIG_W    = 2;
  localparam int RXCNT_W   = 5;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] OFF_CFG_A  = 4'h0;
  localparam logic [3:0] OFF_CFG_B  = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_FRAC0  = 4'h3;
  localparam logic [3:0] OFF_FRAC1  = 4'h4;
  localparam logic [3:0] OFF_FRAC2  = 4'h5;
  localparam logic [3:0] OFF_WCNT   = 4'h6;
  localparam logic [3:0] OFF_DATA_L = 4'h7;
  localparam logic [3:0] OFF_DATA_H = 4'h8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFGA_PORT_EN = 0;
  localparam int CFGA_MASTER  = 1;
  localparam int CFGA_RX_MONO = 2;
  localparam int CFGA_TX_MONO = 3;
  localparam int CFGA_COMPR   = 4;
  localparam int CFGA_EXPAND  = 5;
  localparam int CFGB_WSIZE   = 0;
  localparam int CFGB_TRIG    = 5;
  localparam int FRAC2_DEN8   = 7;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] RST_CFG_A = 8'h00;
  localparam logic [7:0] RST_CFG_B = 8'h0F;
  localparam logic [7:0] RST_FRAC0 = 8'h93;
  localparam logic [7:0] RST_FRAC1 = 8'hE2;
  localparam logic [7:0] RST_FRAC2 = 8'h04;
  localparam logic [1:0] TRIG_NONE  = 2'h0;
  localparam logic [1:0] TRIG_SOF   = 2'h1;
  localparam logic [1:0] TRIG_TIMER = 2'h2;
  localparam logic [1:0] TRIG_PIN   = 2'h3;
  localparam logic [16:0] ULAW_BIAS = 17'h00084;
  localparam logic [16:0] ULAW_CLIP = 17'h07F7B;
  localparam logic [4:0]  RX_FULL   = 5'h10;

endpackage

//--- logic/asp_sck_div.sv
// Purpose: Fractional divider making the link bit clock.
// Assumes: Numerator over denominator stays at or above 3.35.
// Notes:   Half an SCK period lasts num/den system clocks on average.
`timescale 1ns/1ns
module asp_sck_div (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        ce_i,
  // Control
  input  wire logic                        run_i,
  input  wire logic [asp_pkg::NUM_W-1:0]   num_i,
  input  wire logic [asp_pkg::DEN_W-1:0]   den_i,
  // Clock out
  output      logic                        sck_o
);

  logic [asp_pkg::DIV_ACC_W-1:0] acc;
  logic [asp_pkg::DIV_ACC_W-1:0] next_acc;

  assign next_acc = acc + asp_pkg::DIV_ACC_W'(den_i);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc   <= '0;
      sck_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        acc   <= '0;
        sck_o <= 1'b0;
      end else if (next_acc >= asp_pkg::DIV_ACC_W'(num_i)) begin
        acc   <= next_acc - asp_pkg::DIV_ACC_W'(num_i);
        sck_o <= ~sck_o;
      end else begin
        acc <= next_acc;
      end
    end
  end

endmodule

//--- logic/asp_ulaw.sv
// Purpose: Mu-law compander, both directions, combinational.
// Assumes: Samples are two's complement 16-bit.
// Notes:   Callers register the results.
`timescale 1ns/1ns
module asp_ulaw (
  // Compression path
  input  wire logic [15:0] pcm_i,
  output      logic [7:0]  code_o,
  // Expansion path
  input  wire logic [7:0]  code_i,
  output      logic [15:0] pcm_o
);

  always_comb begin
    logic [16:0] mag;
    logic [2:0]  expo;
    logic [16:0] shifted;
    mag  = pcm_i[15] ? 17'(-{pcm_i[15], pcm_i}) : {1'b0, pcm_i};
    expo = 3'h0;
    shifted = 17'h00000;
    if (mag > asp_pkg::ULAW_CLIP) begin
      mag = asp_pkg::ULAW_CLIP;
    end
    mag = mag + asp_pkg::ULAW_BIAS;
    for (int i = 0; i < 8; i++) begin
      if (mag[i + 7]) begin
        expo = 3'(i);
      end
    end
    // The shift reaches ten, so the sum needs four bits.
    shifted = mag >> (4'(expo) + 4'h3);
    code_o  = ~{pcm_i[15], expo, shifted[3:0]};
  end

  always_comb begin
    logic [7:0]  inv;
    logic [16:0] mag;
    inv   = ~code_i;
    mag   = ({13'h0000, inv[3:0]} << 3) + asp_pkg::ULAW_BIAS;
    mag   = (mag << inv[6:4]) - asp_pkg::ULAW_BIAS;
    pcm_o = inv[7] ? 16'(-mag) : mag[15:0];
  end

endmodule

//--- dv/asp_asserts.sv
// Purpose: Port-level checks of the serial audio port.
// Assumes: Clock enable held high; divider ratio of at least 3.
// Notes:   Bound to every asp_top instance.
`timescale 1ns/1ns
module asp_chk (
  // Watched ports
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       sck_o,
  input wire logic       sck_oe_n_o,
  input wire logic       ws_oe_n_o,
  input wire logic       rx_dma_trigger_o,
  input wire logic       tx_dma_trigger_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  property p_mst_on;
    reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[1:0] == 2'h3 |=> !sck_oe_n_o;
  endproperty
  property p_mst_off;
    reg_wr_i && reg_addr_i == 4'h0 && !reg_wdata_i[1] |=> sck_oe_n_o;
  endproperty
  property p_oe_pair;
    ws_oe_n_o == sck_oe_n_o;
  endproperty
  property p_rx_pulse;
    rx_dma_trigger_o |=> !rx_dma_trigger_o;
  endproperty
  property p_tx_pulse;
    tx_dma_trigger_o |=> !tx_dma_trigger_o;
  endproperty
  property p_sck_hi;
    $rose(sck_o) |=> sck_o [*2];
  endproperty
  property p_sck_lo;
    $fell(sck_o) |=> !sck_o [*2];
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_mst_on: assert property (p_mst_on)
    else $error("link pins not driven");
  a_mst_off: assert property (p_mst_off)
    else $error("slave drives link");
  a_oe_pair: assert property (p_oe_pair)
    else $error("enables differ");
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("rx event long");
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("tx event long");
  a_sck_hi: assert property (p_sck_hi)
    else $error("SCK high too short");
  a_sck_lo: assert property (p_sck_lo)
    else $error("SCK low too short");
  c_rx: cover property (rx_dma_trigger_o);
  c_tx: cover property (tx_dma_trigger_o);
  c_sck: cover property ($rose(sck_o));
endmodule
bind asp_top asp_chk i_chk (.core_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sck_o, .sck_oe_n_o, .ws_oe_n_o,
  .rx_dma_trigger_o, .tx_dma_trigger_o);

//--- dv/asp_codec.sv
// Purpose: Behavioural stereo codec on the far side of the link.
// Assumes: Sixteen-bit words, link clocked by the port.
// Notes:   Sends fixed words; zeros once a word is spent.
//          Keeps the last whole word heard from the port.
`timescale 1ns/1ns
module asp_codec #(
  parameter logic [15:0] LEFT  = 16'hA55A,
  parameter logic [15:0] RIGHT = 16'h3CC3
) (
  input  wire logic sck_i,
  input  wire logic ws_i,
  input  wire logic sd_i,
  output      logic sd_o,
  output      logic [15:0] heard_o
);
  logic [15:0] shift_q = 16'h0000;
  logic [15:0] in_q    = 16'h0000;
  initial heard_o = 16'h0000;
  logic        ws_q    = 1'b0;
  logic        load_q  = 1'b0;
  initial sd_o = 1'b0;
  always @(posedge sck_i) begin
    load_q = ws_i != ws_q;
    ws_q   = ws_i;
    in_q    = {in_q[14:0], sd_i};
    heard_o = load_q ? in_q : heard_o;
  end
  always @(negedge sck_i) begin
    shift_q = load_q ? (ws_q ? RIGHT : LEFT) : {shift_q[14:0], 1'b0};
    sd_o    = shift_q[15];
  end
endmodule

//--- dv/asp_top_test.sv
// Purpose: Register-level tests of the serial audio port.
// Assumes: Master mode against the behavioural codec.
// Notes:   Receive and transmit are both checked end to end.
`timescale 1ns/1ns
module asp_top_test;
  logic       core_clk_i = 1'b0, arst_n_i = 1'b0, usb_sof_i = 1'b0;
  logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic       sck_o, sck_oe_n_o, ws_o, ws_oe_n_o, sd_rx, sd_tx_o;
  logic       rx_dma_trigger_o, tx_dma_trigger_o;
  logic [15:0] heard;
  int         err_total = 0, tests_run = 0, cycles = 0;
  // Released link lines are pulled low.
  wire        sck_w = sck_oe_n_o ? 1'b0 : sck_o;
  wire        ws_w  = ws_oe_n_o ? 1'b0 : ws_o;
  asp_top i_dut (.core_clk_i, .arst_n_i, .ce_i(1'b1), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sck_i(sck_w),
    .sck_o, .sck_oe_n_o, .ws_i(ws_w), .ws_o, .ws_oe_n_o, .sd_rx_i(sd_rx),
    .sd_tx_o, .usb_sof_i, .timer_one_cmp_zero_i(1'b0),
    .pin_change_trigger_i(1'b0), .rx_dma_trigger_o, .tx_dma_trigger_o);
  asp_codec i_codec (.sck_i(sck_w), .ws_i(ws_w), .sd_i(sd_tx_o),
    .sd_o(sd_rx), .heard_o(heard));
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH codec word exp %h got %h", e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge core_clk_i);
    tests_run++;
    if ((reg_rdata_o & m) !== e) begin
      err_total++;
      $display("MISMATCH reg %h exp %h got %h", a, e, reg_rdata_o & m);
    end
  endtask
  task automatic wait_rx();
    repeat (2000) begin
      @(posedge core_clk_i);
      if (rx_dma_trigger_o === 1'b1) return;
    end
    err_total++;
    $display("MISMATCH rx event exp 1 got 0");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rd(4'h1, 8'h0F, 8'hFF);
    rd(4'h3, 8'h93, 8'hFF);
    rd(4'h4, 8'hE2, 8'hFF);
    rd(4'h5, 8'h04, 8'hFF);
    rd(4'h9, 8'h00, 8'hFF);
    $display("test reset done");
    wr(4'h0, 8'h20);
    wr(4'h8, 8'h00);
    rd(4'h8, 8'h82, 8'hFF);
    rd(4'h7, 8'h84, 8'hFF);
    wr(4'h0, 8'h10);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    rd(4'h8, 8'hFF, 8'hFF);
    wr(4'h8, 8'h80);
    rd(4'h8, 8'h00, 8'hFF);
    $display("test compander done");
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h2F);
    wr(4'h3, 8'h93);
    wr(4'h0, 8'h03);
    wait_rx();
    wait_rx();
    @(posedge core_clk_i);
    usb_sof_i <= 1'b1;
    @(posedge core_clk_i);
    usb_sof_i <= 1'b0;
    rd(4'h6, 8'h02, 8'hFF);
    rd(4'h2, 8'h21, 8'hE1);
    rd(4'h7, 8'hC3, 8'hFF);
    rd(4'h8, 8'h3C, 8'hFF);
    rd(4'h2, 8'h00, 8'h01);
    wr(4'h0, 8'h23);
    wr(4'h8, 8'h00);
    wait_rx();
    wait_rx();
    chk16(16'h8284, heard);
    wr(4'h0, 8'h07);
    wait_rx();
    rd(4'h2, 8'h01, 8'h21);
    rd(4'h7, 8'h5A, 8'hFF);
    rd(4'h8, 8'hA5, 8'hFF);
    wait_rx();
    rd(4'h8, 8'hA5, 8'hFF);
    $display("test link done");
    finish_test();
  end
endmodule
